// ---- logic/spc_checker.sv ----
// segment privilege checker with AXI4-Lite control registers
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`include "spc_regs.svh"
module spc_checker #(
  parameter int IP_W   = 32,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // request from the pipeline
  input  wire logic                  req_valid,
  input  wire spc_pkg::spc_req_t     req_kind,
  input  wire spc_pkg::spc_form_t    req_form,
  input  wire spc_pkg::spc_dseg_t    req_seg,
  input  wire logic [15:0]           req_sel,
  input  wire logic [IP_W-1:0]       req_ip,
  // fetched descriptor
  input  wire spc_pkg::spc_desc_t    desc_type,
  input  wire logic [1:0]            desc_dlv,
  input  wire logic                  desc_readable,
  input  wire logic                  desc_conforming,
  input  wire logic [IP_W-1:0]       desc_limit,
  // verdict and segment writes
  output logic                       resp_valid,
  output logic                       protection_fault,
  output logic                       seg_we,
  output spc_pkg::spc_dseg_t         seg_idx,
  output logic                       ss_we,
  output logic [15:0]                seg_sel,
  output logic                       cs_we,
  output logic [15:0]                cs_sel,
  output logic [IP_W-1:0]            instruction_pointer,
  // far transfer class and check inputs
  output spc_pkg::spc_xfer_t         xfer_kind,
  output logic [1:0]                 xfer_clv,
  output logic [1:0]                 xfer_dlv,
  output logic [1:0]                 xfer_rlv,
  output logic                       xfer_conforming,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  if (IP_W < 16 || IP_W > 64 || ADDR_W < 4 || ADDR_W > 32)
  begin : g_bad_param
    $error("spc_checker: unsupported parameter value");
  end

  // ========================================================
  // state
  logic [15:0]            code_seg_q;
  logic [15:0]            stack_seg_q;
  logic                   cs_readable_q;
  logic                   check_en_q;
  logic                   last_fault_q;
  spc_pkg::spc_form_t     last_form_q;
  logic [31:0]            fault_cnt_q;
  logic [1:0]             clv;
  logic [1:0]             rlv;
  logic                   data_ok;
  logic                   stack_ok;
  logic                   conf_ok;
  logic                   nonconf_ok;
  logic                   pass_d;
  logic                   seg_we_d;
  logic                   ss_we_d;
  logic                   cs_we_d;
  spc_pkg::spc_xfer_t     xfer_d;

  assign clv = code_seg_q[`SPC_PL_MSB:0]; // [R15]
  assign rlv = req_sel[`SPC_PL_MSB:0]; // [R14]

  spc_priv_cmp u_cmp (
    .clv        (clv),
    .rlv        (rlv),
    .dlv        (desc_dlv),
    .data_ok    (data_ok),
    .stack_ok   (stack_ok),
    .conf_ok    (conf_ok),
    .nonconf_ok (nonconf_ok)
  );

  // ========================================================
  // far target classification
  function automatic spc_pkg::spc_xfer_t classify(
    input spc_pkg::spc_desc_t d
  );
    case (d)
      spc_pkg::SPC_DESC_CODE:       classify = spc_pkg::SPC_XFER_DIRECT;
      spc_pkg::SPC_DESC_CALL_GATE:  classify = spc_pkg::SPC_XFER_CALL_GATE;
      spc_pkg::SPC_DESC_TASK_STATE: classify = spc_pkg::SPC_XFER_TASK_STATE;
      spc_pkg::SPC_DESC_TASK_GATE:  classify = spc_pkg::SPC_XFER_TASK_GATE;
      default:                      classify = spc_pkg::SPC_XFER_NONE;
    endcase
  endfunction

  // ========================================================
  // verdict
  always_comb
  begin
    pass_d   = 1'b0;
    seg_we_d = 1'b0;
    ss_we_d  = 1'b0;
    cs_we_d  = 1'b0;
    xfer_d   = spc_pkg::SPC_XFER_NONE;
    case (req_kind)
      // every load form takes the same path
      spc_pkg::SPC_REQ_DATA:
      begin
        if (desc_type == spc_pkg::SPC_DESC_DATA)
          pass_d = !check_en_q || data_ok; // [R1] [R2]
        else if (desc_type == spc_pkg::SPC_DESC_CODE && desc_readable)
          pass_d = desc_conforming || !check_en_q || data_ok; // [R3] [R4]
        seg_we_d = pass_d; // [R1]
      end
      spc_pkg::SPC_REQ_STACK:
      begin
        if (desc_type == spc_pkg::SPC_DESC_DATA)
          pass_d = !check_en_q || stack_ok; // [R6]
        ss_we_d = pass_d; // [R6]
      end
      spc_pkg::SPC_REQ_CS_READ:
        pass_d = cs_readable_q; // [R5]
      spc_pkg::SPC_REQ_NEAR:
      begin
        pass_d = 1'b1; // [R8]
        xfer_d = spc_pkg::SPC_XFER_NEAR;
      end
      spc_pkg::SPC_REQ_FAR:
      begin
        xfer_d = classify(desc_type); // [R10] [R9]
        case (xfer_d)
          spc_pkg::SPC_XFER_DIRECT:
          begin
            pass_d = (req_ip <= desc_limit) && (!check_en_q ||
                     (desc_conforming ? conf_ok : nonconf_ok)); // [R7] [R12]
            cs_we_d = pass_d; // [R7]
          end
          spc_pkg::SPC_XFER_CALL_GATE,
          spc_pkg::SPC_XFER_TASK_STATE,
          spc_pkg::SPC_XFER_TASK_GATE:
            pass_d = 1'b1;
          default:
            pass_d = 1'b0;
        endcase
      end
      default:
        pass_d = 1'b0;
    endcase
  end

  // ========================================================
  // verdict and write enables, one cycle after the request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      resp_valid       <= 1'b0;
      protection_fault <= 1'b0;
      seg_we           <= 1'b0;
      ss_we            <= 1'b0;
      cs_we            <= 1'b0;
    end
    else
    begin
      resp_valid       <= req_valid; // [R16]
      protection_fault <= req_valid && !pass_d; // [R16]
      seg_we           <= req_valid && seg_we_d; // [R16]
      ss_we            <= req_valid && ss_we_d;
      cs_we            <= req_valid && cs_we_d;
    end
  end

  // payload of the verdict
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seg_idx             <= spc_pkg::SPC_SEG_DATA_PRIMARY;
      seg_sel             <= `SPC_SEL_RESET;
      cs_sel              <= `SPC_SEL_RESET;
      instruction_pointer <= '0;
      xfer_kind           <= spc_pkg::SPC_XFER_NONE;
      xfer_clv            <= 2'h0;
      xfer_dlv            <= 2'h0;
      xfer_rlv            <= 2'h0;
      xfer_conforming     <= 1'b0;
    end
    else if (req_valid)
    begin
      seg_idx             <= req_seg;
      seg_sel             <= req_sel;
      cs_sel              <= {req_sel[15:2], clv}; // [R15]
      instruction_pointer <= req_ip; // [R7]
      xfer_kind           <= xfer_d; // [R10]
      xfer_clv            <= clv; // [R11]
      xfer_dlv            <= desc_dlv; // [R11]
      xfer_rlv            <= rlv; // [R11]
      xfer_conforming     <= desc_conforming; // [R11]
    end
  end

  // ========================================================
  // segment registers holding the current level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      code_seg_q    <= `SPC_SEL_RESET;
      stack_seg_q   <= `SPC_SEL_RESET;
      cs_readable_q <= 1'b0;
    end
    else if (req_valid)
    begin
      if (cs_we_d)
      begin
        code_seg_q    <= {req_sel[15:2], clv}; // [R15]
        cs_readable_q <= desc_readable;
      end
      if (ss_we_d)
        stack_seg_q <= req_sel;
    end
  end

  // status capture; each request overwrites the fault flag and the form
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      last_fault_q <= 1'b0;
      last_form_q  <= spc_pkg::SPC_FORM_MOVE;
    end
    else if (req_valid)
    begin
      last_fault_q <= !pass_d;
      last_form_q  <= req_form; // [R2]
    end
  end

  // ========================================================
  // AXI4-Lite write channel
  logic              aw_got_q;
  logic              w_got_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              do_write;
  logic              clr_cnt;

  function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = 8'(a);
    decode = 3'h4;
    if (a[ADDR_W-1:0] == ADDR_W'(o))
      case (o)
        `SPC_CTRL_OFS:   decode = 3'h0;
        `SPC_STATUS_OFS: decode = 3'h1;
        `SPC_SEGS_OFS:   decode = 3'h2;
        `SPC_FAULTS_OFS: decode = 3'h3;
        default:         decode = 3'h4;
      endcase
  endfunction

  assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;
  assign clr_cnt  = do_write && decode(aw_addr_q) == 3'h3;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        aw_got_q      <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
      end
      else if (do_write)
        aw_got_q <= 1'b0;
      else if (!aw_got_q && !s_axi_bvalid)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        w_got_q      <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
      end
      else if (do_write)
        w_got_q <= 1'b0;
      else if (!w_got_q && !s_axi_bvalid)
        s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SPC_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= decode(aw_addr_q) == 3'h4 ?
                      `SPC_RESP_SLVERR : `SPC_RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // control bit steers the comparisons
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      check_en_q <= `SPC_CTRL_RESET;
    else if (do_write && decode(aw_addr_q) == 3'h0 && w_strb_q[0])
      check_en_q <= w_data_q[`SPC_CTRL_CHECK_EN_BIT];
  end

  // fault counter, a write to the fault count offset clears it; a fault in the same cycle leaves it at 1
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fault_cnt_q <= 32'h0000_0000;
    else if (req_valid && !pass_d)
      fault_cnt_q <= clr_cnt ? 32'h0000_0001 : fault_cnt_q + 32'h0000_0001;
    else if (clr_cnt)
      fault_cnt_q <= 32'h0000_0000;
  end

  // ========================================================
  // AXI4-Lite read channel
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (decode(s_axi_araddr))
      3'h0: rd_word[`SPC_CTRL_CHECK_EN_BIT] = check_en_q;
      3'h1:
      begin
        rd_word[`SPC_STAT_CLV_LSB +: 2]  = clv;
        rd_word[`SPC_STAT_FAULT_BIT]     = last_fault_q;
        rd_word[`SPC_STAT_CSRD_BIT]      = cs_readable_q;
        rd_word[`SPC_STAT_FORM_LSB +: 2] = last_form_q;
      end
      3'h2: rd_word = {stack_seg_q, code_seg_q};
      3'h3: rd_word = fault_cnt_q;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SPC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= decode(s_axi_araddr) == 3'h4 ?
                       `SPC_RESP_SLVERR : `SPC_RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

  // ========================================================
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_data_load;
    req_valid && req_kind == spc_pkg::SPC_REQ_DATA;
  endsequence

  sequence s_far_code;
    req_valid && req_kind == spc_pkg::SPC_REQ_FAR &&
    desc_type == spc_pkg::SPC_DESC_CODE;
  endsequence

  chk_data_deny: assert property ( // [R1]
    s_data_load ##0 (desc_type == spc_pkg::SPC_DESC_DATA && check_en_q &&
    (desc_dlv < clv || desc_dlv < rlv)) |=> protection_fault && !seg_we)
    else $error("data load passed with low dpl");

  chk_data_allow: assert property ( // [R3]
    s_data_load ##0 (desc_type == spc_pkg::SPC_DESC_CODE && desc_readable &&
    !desc_conforming && data_ok) |=> seg_we && !protection_fault)
    else $error("readable code load refused");

  chk_conf_pass: assert property ( // [R4]
    s_data_load ##0 (desc_type == spc_pkg::SPC_DESC_CODE && desc_readable &&
    desc_conforming) |=> seg_we && seg_sel == $past(req_sel))
    else $error("conforming code load refused");

  chk_cs_read: assert property ( // [R5]
    req_valid && req_kind == spc_pkg::SPC_REQ_CS_READ && cs_readable_q
    |=> resp_valid && !protection_fault)
    else $error("override read refused");

  chk_stack_equal: assert property ( // [R6]
    req_valid && req_kind == spc_pkg::SPC_REQ_STACK && check_en_q &&
    (rlv != clv || desc_dlv != clv) |=> protection_fault && !ss_we)
    else $error("stack load passed with level mismatch");

  chk_near_free: assert property ( // [R8]
    req_valid && req_kind == spc_pkg::SPC_REQ_NEAR
    |=> !protection_fault && xfer_kind == spc_pkg::SPC_XFER_NEAR)
    else $error("near transfer faulted");

  chk_far_nonconf: assert property ( // [R9]
    s_far_code ##0 (check_en_q && !desc_conforming && desc_dlv != clv)
    |=> protection_fault && !cs_we)
    else $error("far transfer skipped privilege check");

  chk_far_class: assert property ( // [R10]
    req_valid && req_kind == spc_pkg::SPC_REQ_FAR
    |=> xfer_kind == classify($past(desc_type)))
    else $error("far target misclassified");

  chk_cs_keeps_clv: assert property ( // [R7]
    s_far_code ##0 (pass_d && desc_dlv != clv)
    |=> cs_we && cs_sel[1:0] == $past(clv) ##1 clv == $past(clv, 2))
    else $error("code load changed level or missing");

  chk_verdict_pair: assert property ( // [R16]
    (seg_we || ss_we || cs_we) |-> resp_valid && !protection_fault)
    else $error("write enable without passing verdict");

endmodule

// ---- logic/spc_regs.svh ----
// register offsets, fields, reset values and timing of the checker
// Function
// [R1] data-segment load passes only if dlv >= clv and dlv >= rlv
// [R2] move, pop and far-pointer load forms all get the same check
// [R3] readable nonconforming code loaded as data uses the data check
// [R4] readable conforming code loaded as data always passes
// [R5] read through override of the held readable code segment passes
// [R6] stack-segment load needs clv, rlv and dlv all equal
// [R7] far transfer loads code segment only after limit, type, privilege pass
// [R8] near jump, call and return get no privilege check
// [R9] far jump, call and return always get privilege checks; the checker passes call gate, task state and task gate targets unchecked
// [R10] far target classified: code selector, call gate, task state, task gate
// [R11] direct transfer check inputs: clv, dlv, rlv, conforming flag
// [R12] conforming flag set selects conforming rule, clear nonconforming rule
// [R13] privilege levels are two bits, 0 to 3, larger is less privileged
// [R14] requested level is the two low bits of the loaded selector
// [R15] current level sits in low two bits of code and stack registers
// [R16] verdict appears in the same cycle as the segment write enable
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

// ==========================================================
// register offsets
`define SPC_CTRL_OFS          8'h00
`define SPC_STATUS_OFS        8'h04
`define SPC_SEGS_OFS          8'h08
`define SPC_FAULTS_OFS        8'h0C

// ==========================================================
// fields and reset values
`define SPC_CTRL_CHECK_EN_BIT 0
`define SPC_CTRL_RESET        1'h1
`define SPC_STAT_CLV_LSB      0
`define SPC_STAT_FAULT_BIT    2
`define SPC_STAT_CSRD_BIT     3
`define SPC_STAT_FORM_LSB     4
`define SPC_SEGS_SS_LSB       16
`define SPC_SEL_RESET         16'h0000
`define SPC_PL_MSB            1
`define SPC_RESP_OKAY         2'h0
`define SPC_RESP_SLVERR       2'h2

`endif

// ---- logic/spc_pkg.sv ----
// types shared by the privilege checker
package spc_pkg;

  // ========================================================
  // request and descriptor kinds
  typedef enum logic [2:0] {
    SPC_REQ_NONE,
    SPC_REQ_DATA,
    SPC_REQ_STACK,
    SPC_REQ_CS_READ,
    SPC_REQ_NEAR,
    SPC_REQ_FAR
  } spc_req_t;

  typedef enum logic [1:0] {
    SPC_FORM_MOVE,
    SPC_FORM_POP,
    SPC_FORM_FAR_PTR
  } spc_form_t;

  typedef enum logic [1:0] {
    SPC_SEG_DATA_PRIMARY,
    SPC_SEG_EXTRA_DATA,
    SPC_SEG_AUX_ONE,
    SPC_SEG_AUX_TWO
  } spc_dseg_t;

  typedef enum logic [2:0] {
    SPC_DESC_DATA,
    SPC_DESC_CODE,
    SPC_DESC_CALL_GATE,
    SPC_DESC_TASK_STATE,
    SPC_DESC_TASK_GATE,
    SPC_DESC_OTHER
  } spc_desc_t;

  typedef enum logic [2:0] {
    SPC_XFER_NONE,
    SPC_XFER_NEAR,
    SPC_XFER_DIRECT,
    SPC_XFER_CALL_GATE,
    SPC_XFER_TASK_STATE,
    SPC_XFER_TASK_GATE
  } spc_xfer_t;

endpackage

// ---- logic/spc_priv_cmp.sv ----
// privilege comparisons for data, stack and code targets
`timescale 1ns/1ns
`include "spc_regs.svh"
module spc_priv_cmp (
  // levels
  input  wire logic [`SPC_PL_MSB:0] clv,
  input  wire logic [`SPC_PL_MSB:0] rlv,
  input  wire logic [`SPC_PL_MSB:0] dlv,
  // verdicts
  output logic                      data_ok,
  output logic                      stack_ok,
  output logic                      conf_ok,
  output logic                      nonconf_ok
);

  // ========================================================
  // numeric compares, larger level is less privileged
  always_comb
  begin
    data_ok    = (dlv >= clv) && (dlv >= rlv); // [R1] [R13]
    stack_ok   = (clv == rlv) && (dlv == clv); // [R6]
    conf_ok    = (clv >= dlv); // [R12]
    nonconf_ok = (clv == dlv) && (rlv <= clv); // [R12]
  end

endmodule

// ---- verification/spc_pipe_model.sv ----
// pipeline and descriptor fetch model that feeds the checker
`timescale 1ns/1ns
module spc_pipe_model (
  // clock
  input  wire logic          aclk,
  // request
  output logic               req_valid,
  output spc_pkg::spc_req_t  req_kind,
  output spc_pkg::spc_form_t req_form,
  output spc_pkg::spc_dseg_t req_seg,
  output logic [15:0]        req_sel,
  output logic [31:0]        req_ip,
  // descriptor
  output spc_pkg::spc_desc_t desc_type,
  output logic [1:0]         desc_dlv,
  output logic               desc_readable,
  output logic               desc_conforming,
  output logic [31:0]        desc_limit
);
  initial
  begin
    req_valid = 1'b0;
    req_kind = spc_pkg::SPC_REQ_NONE;
    req_form = spc_pkg::SPC_FORM_MOVE;
    req_seg = spc_pkg::SPC_SEG_DATA_PRIMARY;
    req_sel = 16'h0000;
    req_ip = 32'h00000000;
    desc_type = spc_pkg::SPC_DESC_OTHER;
    desc_dlv = 2'h0;
    desc_readable = 1'b0;
    desc_conforming = 1'b0;
    desc_limit = 32'h0000FFFF;
  end

  // one-cycle request, payload scrambled once taken
  task automatic issue(input spc_pkg::spc_req_t k, input logic [15:0] s,
    input spc_pkg::spc_desc_t t, input logic [1:0] d, input logic rd, c,
    input logic [31:0] ip);
    @(posedge aclk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_form <= spc_pkg::spc_form_t'(s[3:2]);
    req_seg <= spc_pkg::spc_dseg_t'(s[5:4]);
    req_sel <= s;
    req_ip <= ip;
    desc_type <= t;
    desc_dlv <= d;
    desc_readable <= rd;
    desc_conforming <= c;
    @(posedge aclk);
    req_valid <= 1'b0;
    req_sel <= ~s;
    req_ip <= ~ip;
    desc_dlv <= ~d;
  endtask
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the segment privilege checker
`timescale 1ns/1ns
`include "spc_regs.svh"
module testbench;
  logic aclk, aresetn, req_valid, desc_readable, desc_conforming;
  spc_pkg::spc_req_t  req_kind;
  spc_pkg::spc_form_t req_form;
  spc_pkg::spc_dseg_t req_seg, seg_idx;
  spc_pkg::spc_desc_t desc_type;
  spc_pkg::spc_xfer_t xfer_kind;
  logic [15:0] req_sel, seg_sel, cs_sel;
  logic [31:0] req_ip, desc_limit, instruction_pointer;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  desc_dlv, xfer_clv, xfer_dlv, xfer_rlv;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        resp_valid, protection_fault, seg_we, ss_we, cs_we;
  logic        xfer_conforming;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          err_count = 0;
  int          num_checks = 0;

  spc_checker spc_checker_inst (.*);
  spc_pipe_model spc_pipe_model_inst (.*);

  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  // ==========================================================
  // reporting
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 40)
    begin
      err_count++;
      $display("[ERR] handshake wait expired");
      give_verdict();
    end
  endtask

  // ==========================================================
  // register bus
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    bit ta = 0;
    bit tw = 0;
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw) && n < 40)
    begin
      @(posedge aclk);
      n++;
      ta |= s_axi_awready;
      tw |= s_axi_wready;
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end
    tmo(n);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (!s_axi_bvalid && n < 40);
    tmo(n);
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ex,
    input logic [1:0] er);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (!s_axi_arready && n < 40);
    tmo(n);
    s_axi_arvalid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (!s_axi_rvalid && n < 40);
    tmo(n);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
    chk("rdata", s_axi_rdata, ex);
  endtask

  // ==========================================================
  // pipeline request with verdict
  task automatic ld(input spc_pkg::spc_req_t k, input logic [15:0] s,
    input spc_pkg::spc_desc_t t, input logic [1:0] d, input logic rd, c,
    input logic [31:0] ip, input logic ef);
    logic p;
    p = !ef;
    spc_pipe_model_inst.issue(k, s, t, d, rd, c, ip);
    @(posedge aclk);
    chk("resp_valid", 32'(resp_valid), 32'h1);
    chk("fault", 32'(protection_fault), 32'(ef));
    chk("seg_we", 32'(seg_we), 32'(p && k == spc_pkg::SPC_REQ_DATA));
    chk("ss_we", 32'(ss_we), 32'(p && k == spc_pkg::SPC_REQ_STACK));
    chk("cs_we", 32'(cs_we), 32'(p && k == spc_pkg::SPC_REQ_FAR
      && t == spc_pkg::SPC_DESC_CODE));
    if (p && k == spc_pkg::SPC_REQ_DATA)
    begin
      chk("seg_sel", 32'(seg_sel), 32'(s));
      chk("seg_idx", 32'(seg_idx), 32'(s[5:4]));
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs;
    axr(`SPC_CTRL_OFS, 32'h00000001, `SPC_RESP_OKAY);
    axr(`SPC_SEGS_OFS, 32'h00000000, `SPC_RESP_OKAY);
    axr(8'h10, 32'h00000000, `SPC_RESP_SLVERR);
    axw(8'h10, 32'h00000000, `SPC_RESP_SLVERR);
    $display("test regs done");
  endtask

  task automatic t_data;
    for (int r = 0; r < 4; r++)
      for (int d = 0; d < 4; d++)
        ld(spc_pkg::SPC_REQ_DATA, {10'h0, 2'(r), 2'(d % 3), 2'(r)},
          spc_pkg::SPC_DESC_DATA, 2'(d), 1'b0, 1'b0, 32'h0,
          d < r);
    ld(spc_pkg::SPC_REQ_DATA, 16'h0003, spc_pkg::SPC_DESC_CODE, 2'h0,
      1'b1, 1'b1, 32'h0, 1'b0);
    ld(spc_pkg::SPC_REQ_DATA, 16'h0003, spc_pkg::SPC_DESC_CODE, 2'h0,
      1'b1, 1'b0, 32'h0, 1'b1);
    ld(spc_pkg::SPC_REQ_DATA, 16'h0002, spc_pkg::SPC_DESC_CODE, 2'h3,
      1'b1, 1'b0, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++)
      ld(spc_pkg::SPC_REQ_STACK, 16'h5A40 | 16'(i[0]),
        spc_pkg::SPC_DESC_DATA, 2'(i[1]), 1'b0, 1'b0, 32'h0,
        i != 0);
    $display("test data done");
  endtask

  task automatic t_far;
    ld(spc_pkg::SPC_REQ_CS_READ, 16'h0, spc_pkg::SPC_DESC_CODE, 2'h0,
      1'b1, 1'b0, 32'h0, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      ld(spc_pkg::SPC_REQ_FAR, {12'h120, 2'(i), 2'(i >> 2)},
        spc_pkg::SPC_DESC_CODE, 2'(i), 1'b0, i[3], 32'h100,
        i[1:0] != 0 || (!i[3] && i[3:2] != 0));
      chk("xfer_kind", 32'(xfer_kind), 32'(spc_pkg::SPC_XFER_DIRECT));
      chk("xfer_clv", 32'(xfer_clv), 32'h0);
      chk("xfer_dlv", 32'(xfer_dlv), 32'(i[1:0]));
      chk("xfer_rlv", 32'(xfer_rlv), 32'(i[3:2]));
      chk("xfer_conf", 32'(xfer_conforming), 32'(i[3]));
    end
    ld(spc_pkg::SPC_REQ_FAR, 16'h1238, spc_pkg::SPC_DESC_CODE, 2'h0,
      1'b1, 1'b0, 32'h00010000, 1'b1);
    ld(spc_pkg::SPC_REQ_FAR, 16'h123B, spc_pkg::SPC_DESC_CODE, 2'h0,
      1'b1, 1'b1, 32'h0000FFFF, 1'b0);
    chk("cs_sel", 32'(cs_sel), 32'h00001238);
    chk("ip", instruction_pointer, 32'h0000FFFF);
    axr(`SPC_SEGS_OFS, 32'h5A401238, `SPC_RESP_OKAY);
    ld(spc_pkg::SPC_REQ_CS_READ, 16'h0, spc_pkg::SPC_DESC_DATA, 2'h3,
      1'b0, 1'b0, 32'h0, 1'b0);
    $display("test far done");
  endtask

  task automatic t_kinds;
    spc_pkg::spc_desc_t dt[5] = '{spc_pkg::SPC_DESC_CALL_GATE,
      spc_pkg::SPC_DESC_TASK_STATE, spc_pkg::SPC_DESC_TASK_GATE,
      spc_pkg::SPC_DESC_DATA, spc_pkg::SPC_DESC_OTHER};
    spc_pkg::spc_xfer_t xt[5] = '{spc_pkg::SPC_XFER_CALL_GATE,
      spc_pkg::SPC_XFER_TASK_STATE, spc_pkg::SPC_XFER_TASK_GATE,
      spc_pkg::SPC_XFER_NONE, spc_pkg::SPC_XFER_NONE};
    for (int i = 0; i < 5; i++)
    begin
      ld(spc_pkg::SPC_REQ_FAR, 16'h0040, dt[i], 2'h0, 1'b0, 1'b0,
        32'h10, i > 2);
      chk("xfer_kind", 32'(xfer_kind), 32'(xt[i]));
    end
    ld(spc_pkg::SPC_REQ_NEAR, 16'h0043, spc_pkg::SPC_DESC_CODE, 2'h3,
      1'b0, 1'b0, 32'h20000, 1'b0);
    ld(spc_pkg::SPC_REQ_FAR, 16'h0043, spc_pkg::SPC_DESC_CODE, 2'h3,
      1'b0, 1'b0, 32'h10, 1'b1);
    $display("test kinds done");
  endtask

  task automatic t_ctrl;
    axw(`SPC_FAULTS_OFS, 32'h0, `SPC_RESP_OKAY);
    axw(`SPC_CTRL_OFS, 32'h0, `SPC_RESP_OKAY);
    ld(spc_pkg::SPC_REQ_DATA, 16'h0003, spc_pkg::SPC_DESC_DATA, 2'h0,
      1'b0, 1'b0, 32'h0, 1'b0);
    axw(`SPC_CTRL_OFS, 32'h1, `SPC_RESP_OKAY);
    ld(spc_pkg::SPC_REQ_DATA, 16'h0003, spc_pkg::SPC_DESC_DATA, 2'h0,
      1'b0, 1'b0, 32'h0, 1'b1);
    ld(spc_pkg::SPC_REQ_STACK, 16'h0009, spc_pkg::SPC_DESC_DATA, 2'h1,
      1'b0, 1'b0, 32'h0, 1'b1);
    axr(`SPC_FAULTS_OFS, 32'h2, `SPC_RESP_OKAY);
    axr(`SPC_STATUS_OFS, 32'h0000002C, `SPC_RESP_OKAY);
    $display("test ctrl done");
  endtask

  initial
  begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_data();
    t_far();
    t_kinds();
    t_ctrl();
    give_verdict();
  end
endmodule
